// ### adc_chain.sv
`timescale 1ns/1ns
// Serial result path with daisy chain and power-down control of the converter.
module adc_chain (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // AHB-Lite slave.
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Device pins.
  input wire adc_chain_pkg::pin_in_t i_pins,
  output logic o_serial_result_out,
  output logic o_shift_clock,
  output logic o_shift_clock_oe,
  output logic o_busy_b,
  // Converter core.
  input wire logic [15:0] i_core_result,
  output adc_chain_pkg::power_out_t o_power
);
  import adc_chain_pkg::*;

  pin_in_t pins_s;
  logic [PIN_W-1:0] pins_v;

  // Every pin passes two flops before any logic sees it.
  pin_sync #(
    .WIDTH(PIN_W)
  ) u_pin_sync (
    .i_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_pins),
    .o_sync(pins_v)
  );

  assign pins_s = pin_in_t'(pins_v);

  // Edge detection on the synchronised shift clock and convert pin.
  logic sclk_d_r;
  logic conv_d_r;
  logic ext_rise;
  logic conv_rise;
  logic ext_mode;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_d_r <= 1'b0;
      conv_d_r <= 1'b0;
    end else begin
      sclk_d_r <= pins_s.shift_clock;
      conv_d_r <= pins_s.convert_start;
    end
  end

  // The pin picks the clock source; the host is trusted to pick external.
  assign ext_mode = pins_s.ext_clock_sel;
  // Shifting never depends on the power-down pins.
  assign ext_rise = ext_mode & pins_s.shift_clock & ~sclk_d_r;
  assign conv_rise = pins_s.convert_start & ~conv_d_r;

  // Bus side signals shared by the groups below.
  logic sw_start;
  logic sw_clr_junk;

  // Conversion sequencer.
  conv_state_t st_r;
  conv_state_t st_nxt;
  logic [6:0] conv_cnt_r;
  logic [6:0] conv_cnt_nxt;
  logic start_apd_r;
  logic start_apd_nxt;
  logic junk_r;
  logic junk_nxt;
  logic start_req;
  logic load;

  assign start_req = (st_r == ST_IDLE) & (conv_rise | sw_start);
  assign load = (st_r == ST_LOAD);

  always_comb begin
    st_nxt = st_r;
    conv_cnt_nxt = conv_cnt_r;
    start_apd_nxt = start_apd_r;
    junk_nxt = junk_r;
    case (st_r)
      ST_IDLE: begin
        if (start_req) begin
          st_nxt = ST_CONV;
          conv_cnt_nxt = 7'(CONV_CYC - 1);
          start_apd_nxt = pins_s.analog_powerdown;
        end
      end
      ST_CONV: begin
        if (conv_cnt_r == 7'h00) begin
          st_nxt = ST_LOAD;
        end else begin
          conv_cnt_nxt = conv_cnt_r - 7'h01;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    // A fresh junk result wins over a clear in the same cycle.
    if (sw_clr_junk) begin
      junk_nxt = 1'b0;
    end
    if (load && start_apd_r) begin
      junk_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= ST_IDLE;
      conv_cnt_r <= 7'h00;
      start_apd_r <= 1'b0;
      junk_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      conv_cnt_r <= conv_cnt_nxt;
      start_apd_r <= start_apd_nxt;
      junk_r <= junk_nxt;
    end
  end

  // Output register, serial output and both shift clock sources.
  logic [15:0] sr_r;
  logic [15:0] sr_nxt;
  logic [15:0] res_r;
  logic [15:0] res_nxt;
  logic out_r;
  logic out_nxt;
  logic [5:0] edge_cnt_r;
  logic [5:0] edge_cnt_nxt;
  logic consumed_r;
  logic consumed_nxt;
  logic tag_start_r;
  logic tag_start_nxt;
  logic [5:0] tog_r;
  logic [5:0] tog_nxt;
  logic [1:0] div_r;
  logic [1:0] div_nxt;
  logic sclk_out_r;
  logic sclk_out_nxt;
  logic full_pd;
  // Previous full power-down level, so that a drop happens only on entry.
  logic full_pd_r;
  logic full_pd_nxt;

  assign full_pd = pins_s.analog_powerdown & pins_s.reference_powerdown;

  always_comb begin
    sr_nxt = sr_r;
    res_nxt = res_r;
    out_nxt = out_r;
    edge_cnt_nxt = edge_cnt_r;
    consumed_nxt = consumed_r;
    tag_start_nxt = tag_start_r;
    tog_nxt = tog_r;
    div_nxt = div_r;
    sclk_out_nxt = sclk_out_r;
    full_pd_nxt = full_pd;
    // Internal mode: the old result goes out while the new one converts.
    if (start_req && !ext_mode) begin
      tag_start_nxt = pins_s.chain_in;
      tog_nxt = INT_TOGGLES;
      div_nxt = 2'(INT_HALF_CYC - 1);
    end else if (tog_r != 6'h00) begin
      if (div_r != 2'h0) begin
        div_nxt = div_r - 2'h1;
      end else begin
        div_nxt = 2'(INT_HALF_CYC - 1);
        tog_nxt = tog_r - 6'h01;
        sclk_out_nxt = ~sclk_out_r;
        if (!sclk_out_r) begin
          out_nxt = sr_r[15];
          sr_nxt = {sr_r[14:0], tag_start_r};
        end else if (tog_r == 6'h01) begin
          // After the sixteenth pulse the line rests at the sampled chain level.
          out_nxt = tag_start_r;
          consumed_nxt = 1'b1;
        end
      end
    end
    // External mode: one result or chain bit moves per rising edge.
    if (ext_rise) begin
      out_nxt = sr_r[15];
      sr_nxt = {sr_r[14:0], pins_s.chain_in};
      // Rising edge 17 puts the first chain bit out, so it holds across the
      // 17th falling and 18th rising edge.
      if (edge_cnt_r != 6'h3F) begin
        edge_cnt_nxt = edge_cnt_r + 6'h01;
      end
      if (edge_cnt_r == RESULT_BITS_W - 6'h01) begin
        consumed_nxt = 1'b1;
      end
    end
    // Full power-down keeps an unread word; a word already sent is dropped
    // once, on entry. Clearing only on entry keeps the chain path alive while
    // powered down, so upstream words still pass through afterwards.
    if (full_pd && !full_pd_r && consumed_r) begin
      sr_nxt = RESULT_RST;
    end
    // A new result replaces the register; analog power-down alone holds it.
    if (load) begin
      sr_nxt = i_core_result;
      res_nxt = i_core_result;
      edge_cnt_nxt = 6'h00;
      consumed_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sr_r <= RESULT_RST;
      res_r <= RESULT_RST;
      out_r <= 1'b0;
      edge_cnt_r <= 6'h00;
      consumed_r <= 1'b0;
      tag_start_r <= 1'b0;
      tog_r <= 6'h00;
      div_r <= 2'h0;
      sclk_out_r <= 1'b0;
      full_pd_r <= 1'b0;
    end else begin
      sr_r <= sr_nxt;
      res_r <= res_nxt;
      out_r <= out_nxt;
      edge_cnt_r <= edge_cnt_nxt;
      consumed_r <= consumed_nxt;
      tag_start_r <= tag_start_nxt;
      tog_r <= tog_nxt;
      div_r <= div_nxt;
      sclk_out_r <= sclk_out_nxt;
      full_pd_r <= full_pd_nxt;
    end
  end

  // Power enables toward the analog section, registered.
  // Registering costs a cycle but keeps decode glitches off the analog switches.
  power_out_t pwr_r;
  power_out_t pwr_nxt;

  always_comb begin
    // Reference power-down touches the on-chip reference only.
    pwr_nxt.reference_enable = ~pins_s.reference_powerdown;
    pwr_nxt.buffer_enable = ~pins_s.analog_powerdown;
    pwr_nxt.analog_enable = ~pins_s.analog_powerdown;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pwr_r <= '0;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  // AHB-Lite slave: address phase captured, write applied in data phase.
  logic wr_pend_r;
  logic wr_pend_nxt;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_addr_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic addr_ok;
  logic [31:0] status_w;

  // Transfer size is ignored: every register is one aligned word.
  assign addr_ok = i_hsel & i_htrans[1] & i_hready;
  assign sw_start = wr_pend_r & (wr_addr_r == OFF_CTRL) & i_hwdata[CTRL_START_BIT];
  assign sw_clr_junk = wr_pend_r & (wr_addr_r == OFF_STATUS) & i_hwdata[ST_JUNK_BIT];

  // Status word assembled field by field; unused bits read as zero.
  always_comb begin
    status_w = 32'h00000000;
    status_w[ST_BUSY_BIT] = (st_r != ST_IDLE);
    status_w[ST_EXT_BIT] = ext_mode;
    status_w[ST_CONSUMED_BIT] = consumed_r;
    status_w[ST_JUNK_BIT] = junk_r;
    status_w[ST_APD_BIT] = pins_s.analog_powerdown;
    status_w[ST_RPD_BIT] = pins_s.reference_powerdown;
    status_w[ST_CNT_LSB +: 6] = edge_cnt_r;
  end

  always_comb begin
    wr_pend_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    rdata_nxt = rdata_r;
    if (addr_ok) begin
      wr_pend_nxt = i_hwrite;
      wr_addr_nxt = {i_haddr[7:2], 2'h0};
      // Read data is fetched at the address phase so it comes from a flop.
      if (i_hwrite) begin
        rdata_nxt = 32'h00000000;
      end else if ({i_haddr[7:2], 2'h0} == OFF_CTRL) begin
        rdata_nxt = 32'h00000000;
      end else if ({i_haddr[7:2], 2'h0} == OFF_STATUS) begin
        rdata_nxt = status_w;
      end else if ({i_haddr[7:2], 2'h0} == OFF_RESULT) begin
        rdata_nxt = {16'h0000, res_r};
      end else begin
        rdata_nxt = 32'h00000000;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rdata_r <= 32'h00000000;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Zero wait states and an OKAY answer to every access.
  assign o_hrdata = rdata_r;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  // Pin outputs; the shift clock pin is driven only in internal mode.
  // The serial output is a flop, so the host sees clean levels between edges.
  assign o_serial_result_out = out_r;
  assign o_shift_clock = sclk_out_r;
  assign o_shift_clock_oe = ~ext_mode;
  assign o_busy_b = (st_r == ST_IDLE);
  assign o_power = pwr_r;

endmodule // adc_chain

// ### adc_chain_pkg.sv
// Functional notes
// - Each serial output feeds the next chain input; the last feeds the host.
// - Every converter shifts one bit toward the host per external shift clock.
// - At read end the serial output shows the chain level sampled at start.
// - After 16 result bits the chain input appears on the 17th clock.
// - With two converters the 17th clock brings upstream MSB downstream.
// - Both power-downs high keep the result unless already shifted out.
// - Analog power-down alone keeps the result readable.
// - A conversion started in analog power-down yields a meaningless result.
// - Digital logic and shift path stay active whatever the power-downs.
// - Reference power-down disables only the on-chip reference.
// - In external mode one chain bit is sampled per shift clock pulse.
// - First chain bit shows at 17th falling and 18th rising edge.
package adc_chain_pkg;

  // Clock and timing.
  localparam int unsigned REF_CLK_NS = 40;
  localparam int unsigned CONV_TIME_NS = 2200;
  localparam int unsigned CONV_CYC = (CONV_TIME_NS + REF_CLK_NS - 1) / REF_CLK_NS;
  localparam int unsigned INT_CLK_PERIOD_NS = 96;
  localparam int unsigned INT_HALF_RAW = (INT_CLK_PERIOD_NS / 2) / REF_CLK_NS;
  localparam int unsigned INT_HALF_CYC = (INT_HALF_RAW < 1) ? 1 : INT_HALF_RAW;
  localparam int unsigned RESULT_BITS = 16;
  localparam logic [5:0] RESULT_BITS_W = 6'h10;
  localparam logic [5:0] INT_TOGGLES = 6'h20;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_RESULT = 8'h08;

  // Field positions.
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_EXT_BIT = 1;
  localparam int unsigned ST_CONSUMED_BIT = 2;
  localparam int unsigned ST_JUNK_BIT = 3;
  localparam int unsigned ST_APD_BIT = 4;
  localparam int unsigned ST_RPD_BIT = 5;
  localparam int unsigned ST_CNT_LSB = 8;

  // Reset values.
  localparam logic [15:0] RESULT_RST = 16'h0000;

  // Conversion sequencer states, Gray along idle, convert, load.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_LOAD = 2'b11
  } conv_state_t;

  // Pins that arrive from outside the clock domain.
  typedef struct packed {
    logic shift_clock;
    logic chain_in;
    logic ext_clock_sel;
    logic analog_powerdown;
    logic reference_powerdown;
    logic convert_start;
  } pin_in_t;

  localparam int unsigned PIN_W = $bits(pin_in_t);

  // Enables toward the analog section.
  typedef struct packed {
    logic reference_enable;
    logic buffer_enable;
    logic analog_enable;
  } power_out_t;

endpackage

// ### pin_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser for a group of asynchronous pins.
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Pins in and synchronised copies out.
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_r;

  // The first stage is read by the second stage only.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule // pin_sync

// ### adc_chain_assertions.sv
`timescale 1ns/1ns
// Watches bus answers, busy timing, power enables and serial output movement at the ports.
module adc_chain_assertions
  import adc_chain_pkg::*;
(
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Bus.
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  // Pins and power.
  input wire adc_chain_pkg::pin_in_t i_pins,
  input wire logic o_serial_result_out,
  input wire logic o_shift_clock_oe,
  input wire logic o_busy_b,
  input wire adc_chain_pkg::power_out_t o_power
);
  localparam int unsigned BUSY_LOW = CONV_CYC + 1;
  logic [7:0] lo_cnt_r;
  logic [7:0] lo_cnt_nxt;
  logic [5:0] sc_hist_r;
  logic [5:0] sc_hist_nxt;
  logic rose_win;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  // Busy length and a pin history, so a data change can be tied to the rise that caused it
  // despite the synchroniser delay.
  always_comb begin
    lo_cnt_nxt = o_busy_b ? 8'h00 : lo_cnt_r + 8'h01;
    sc_hist_nxt = {sc_hist_r[4:0], i_pins.shift_clock};
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lo_cnt_r <= 8'h00;
      sc_hist_r <= 6'h00;
    end else begin
      lo_cnt_r <= lo_cnt_nxt;
      sc_hist_r <= sc_hist_nxt;
    end
  end
  assign rose_win = |(sc_hist_r[4:2] & ~sc_hist_r[5:3]);
  property p_bus_okay; o_hreadyout && !o_hresp; endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready");
  property p_busy_len; $rose(o_busy_b) |-> lo_cnt_r == BUSY_LOW; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_apd_off; $rose(i_pins.analog_powerdown) |-> ##[1:4] !o_power.analog_enable;
  endproperty
  a_apd_off: assert property (p_apd_off) else $error("analog not powered down");
  property p_buf_follow; o_power.buffer_enable == o_power.analog_enable; endproperty
  a_buf_follow: assert property (p_buf_follow) else $error("buffer enable wrong");
  property p_ref_off;
    $rose(i_pins.reference_powerdown) |-> ##[1:4] !o_power.reference_enable;
  endproperty
  a_ref_off: assert property (p_ref_off) else $error("reference still on");
  property p_out_on_clock;
    (i_pins.ext_clock_sel && $changed(o_serial_result_out)) |-> rose_win;
  endproperty
  a_out_on_clock: assert property (p_out_on_clock) else $error("data moved unclocked");
  property p_oe_ext; $rose(i_pins.ext_clock_sel) |-> ##[2:4] !o_shift_clock_oe; endproperty
  a_oe_ext: assert property (p_oe_ext) else $error("clock output still driven");
  property p_unmapped;
    (i_hsel && i_htrans[1] && i_hready && !i_hwrite && i_haddr[7:2] > 6'h02) |=> o_hrdata == 0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  c_conv: cover property ($rose(o_busy_b));
  c_shift: cover property (i_pins.ext_clock_sel && $changed(o_serial_result_out));
  c_apd: cover property ($rose(i_pins.analog_powerdown));
endmodule // adc_chain_assertions

// ### host_link_model.sv
`timescale 1ns/1ns
// Host side of the chain: makes a gated shift clock and feeds upstream chain bits.
module host_link_model (
  // Serial data from the block.
  input wire logic i_serial_result_out,
  // Clock and chain data toward the block.
  output logic o_shift_clock,
  output logic o_chain_in
);
  logic [31:0] captured;
  // The clock stands low outside reads and only runs during sampling.
  initial begin
    o_shift_clock = 1'b0;
    o_chain_in = 1'b0;
    captured = 32'h0;
  end
  // One bit per pulse; data are taken just before the next rise, when settled.
  task automatic read_bits(input int n, input logic [31:0] pat);
    captured = 32'h0;
    for (int k = 0; k < n; k++) begin
      o_chain_in <= pat[31-k];
      #20 o_shift_clock = 1'b1;
      #180 o_shift_clock = 1'b0;
      #120 captured = {captured[30:0], i_serial_result_out};
    end
  endtask
endmodule // host_link_model

// ### test_adc_serial_chain_powerdown.sv
`timescale 1ns/1ns
// Drives the block over the bus and the chain pins and checks what it returns.
module test_adc_serial_chain_powerdown;
  import adc_chain_pkg::*;
  // Power-up recovery wait of 1 ms, counted in clock cycles.
  localparam int RECOVER_CYC = 1000000 / REF_CLK_NS;
  logic i_ref_clk;
  logic i_rst_b;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic hrdy;
  logic [31:0] hrdata;
  logic ext_sel;
  logic apd;
  logic rpd;
  logic sc;
  logic ci;
  logic cv;
  logic ser;
  logic oe;
  logic busy_b;
  logic [15:0] core;
  power_out_t pwr;
  pin_in_t pins;
  logic [31:0] d;
  int num_errors;
  int comparisons;
  assign pins = {sc, ci, ext_sel, apd, rpd, cv};
  // Clock.
  always #20 i_ref_clk = ~i_ref_clk;
  adc_chain i_dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_hsel(1'b1), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(), .i_pins(pins), .o_serial_result_out(ser),
    .o_shift_clock(), .o_shift_clock_oe(oe), .o_busy_b(busy_b), .i_core_result(core),
    .o_power(pwr));
  host_link_model u_host (.i_serial_result_out(ser), .o_shift_clock(sc), .o_chain_in(ci));
  // Compares and counts.
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One single transfer; hold each phase until ready is seen high.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge i_ref_clk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge i_ref_clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge i_ref_clk); while (hrdy !== 1'b1);
    d = hrdata;
  endtask
  // Start by the convert pin or by the control register, then wait it out.
  task automatic convert(input logic [15:0] v, input logic by_pin);
    core <= v;
    if (by_pin) begin
      @(posedge i_ref_clk);
      cv <= 1'b1;
      wait (busy_b === 1'b0);
      @(posedge i_ref_clk);
      cv <= 1'b0;
    end else begin
      bus(1'b1, OFF_CTRL, 32'h1);
      wait (busy_b === 1'b0);
    end
    wait (busy_b === 1'b1);
    repeat (2) @(posedge i_ref_clk);
  endtask
  task automatic final_report();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog, well beyond the recovery wait plus under a thousand test cycles.
  initial begin
    repeat (40000) @(posedge i_ref_clk);
    num_errors++;
    final_report();
  end
  // Test sequence.
  initial begin
    i_ref_clk = 1'b0;
    i_rst_b = 1'b0;
    {haddr, htrans, hwrite, hwdata, ext_sel, apd, rpd, cv, core} = '0;
    num_errors = 0;
    comparisons = 0;
    repeat (6) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    bus(1'b0, OFF_RESULT, 32'h0);
    check("result_rst", d, {16'h0, RESULT_RST});
    bus(1'b0, 8'h0C, 32'h0);
    check("unmapped", d, 32'h0);
    convert(16'hC3A5, 1'b0);
    check("oe_int", {31'h0, oe}, 32'h1);
    $display("test reset and internal mode done");
    ext_sel <= 1'b1;
    convert(16'hA5C3, 1'b0);
    bus(1'b0, OFF_RESULT, 32'h0);
    check("result", d, 32'hA5C3);
    u_host.read_bits(20, 32'hA000_0000);
    check("chain", {12'h0, u_host.captured[19:0]}, {12'h0, 16'hA5C3, 4'hA});
    bus(1'b0, OFF_STATUS, 32'h0);
    check("status", {24'h0, d[13:8], d[1:0]}, 32'h52);
    $display("test chain shift done");
    apd <= 1'b1;
    repeat (5) @(posedge i_ref_clk);
    check("power_apd", {29'h0, pwr}, 32'h4);
    bus(1'b0, OFF_RESULT, 32'h0);
    check("result_apd", d, 32'hA5C3);
    convert(16'h1234, 1'b0);
    bus(1'b0, OFF_STATUS, 32'h0);
    check("junk_set", {31'h0, d[3]}, 32'h1);
    bus(1'b1, OFF_STATUS, 32'h8);
    bus(1'b0, OFF_STATUS, 32'h0);
    check("junk_clr", {31'h0, d[3]}, 32'h0);
    apd <= 1'b0;
    // Give the analog section its recovery time before trusting a result.
    repeat (RECOVER_CYC) @(posedge i_ref_clk);
    $display("test analog power-down done");
    convert(16'h3C5A, 1'b1);
    apd <= 1'b1;
    rpd <= 1'b1;
    repeat (5) @(posedge i_ref_clk);
    check("power_full", {29'h0, pwr}, 32'h0);
    u_host.read_bits(16, 32'hFFFF_0000);
    check("kept", {16'h0, u_host.captured[15:0]}, 32'h3C5A);
    apd <= 1'b0;
    repeat (5) @(posedge i_ref_clk);
    check("power_ref", {29'h0, pwr}, 32'h3);
    // Power down again with the word already sent: it is dropped on entry,
    // while chain bits from upstream still pass through.
    apd <= 1'b1;
    repeat (5) @(posedge i_ref_clk);
    u_host.read_bits(20, 32'hA000_0000);
    check("dropped", {12'h0, u_host.captured[19:0]}, 32'h0000000A);
    apd <= 1'b0;
    rpd <= 1'b0;
    $display("test full power-down done");
    final_report();
  end
endmodule // test_adc_serial_chain_powerdown
bind adc_chain adc_chain_assertions u_chk (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
  .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
  .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .i_pins(i_pins), .o_serial_result_out(o_serial_result_out),
  .o_shift_clock_oe(o_shift_clock_oe), .o_busy_b(o_busy_b), .o_power(o_power));
